//--- design/spp_pkg.sv
// Constants shared by the six-pin port: register map, reset values,
// pin indices and steering bit positions.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package spp_pkg;

    // Port geometry
    localparam int          NPINS          = 6;     // Pins on this port
    localparam int          ADDR_W         = 8;     // Register address width
    localparam int          PIN_INPUT_ONLY = 3;     // Pin with no driver

    // Register byte offsets
    localparam logic [7:0]  OFS_PIN_VALUE  = 8'h00; // Pin levels / latch
    localparam logic [7:0]  OFS_DIRECTION  = 8'h04; // Direction bits
    localparam logic [7:0]  OFS_LATCH      = 8'h08; // Output latch
    localparam logic [7:0]  OFS_ANALOG     = 8'h0c; // Analog select bits
    localparam logic [7:0]  OFS_THRESH     = 8'h10; // Threshold select bits
    localparam logic [7:0]  OFS_STEER0     = 8'h14; // Pin steering control 0

    // Reset values
    localparam logic [5:0]  RST_DIRECTION  = 6'h3f; // All pins input
    localparam logic [5:0]  RST_LATCH      = 6'h00; // Latch cleared
    localparam logic [5:0]  RST_ANALOG     = 6'h3f; // All pins analog
    localparam logic [5:0]  RST_THRESH     = 6'h00; // TTL thresholds
    localparam logic [5:0]  RST_STEER0     = 6'h00; // Default pins

    // Field masks
    localparam logic [5:0]  LATCH_MASK     = 6'h37; // Latch has no bit 3
    localparam logic [5:0]  DIR_FORCE1     = 6'h08; // Bit 3 always input

    // Threshold select encoding
    localparam logic        THR_SCHMITT    = 1'b1;  // 1 Schmitt, 0 TTL

    // Steering control bit positions
    localparam int          STB_CAPTURE2   = 0;     // Alternate on line 5
    localparam int          STB_PWM2_OUT2  = 1;     // Alternate on line 4
    localparam int          STB_PWM1_OUT3  = 2;     // Port C lines 3 / 1
    localparam int          STB_PWM1_OUT4  = 3;     // Port C lines 2 / 0
    localparam int          STB_SERIAL2_SEL  = 4;   // Input, alt on line 3
    localparam int          STB_SERIAL2_DOUT = 5;   // Alternate on line 4

    // Steered outputs whose alternate pin is on this port
    localparam logic [5:0]  ALT_ON_PA      = 6'h23;
    // Steered functions that are outputs
    localparam logic [5:0]  OUT_FUNCS      = 6'h2f;

    // Port lines that take steered outputs
    localparam int          PA_LINE4       = 4;
    localparam int          PA_LINE5       = 5;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

//--- design/spp_cond_if.sv
// Carrier between the port control and the pin input conditioner.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface spp_cond_if;
    logic [spp_pkg::NPINS-1:0] thr_sel;  // Threshold choice per pin
    logic [spp_pkg::NPINS-1:0] ana_sel;  // Analog mode per pin
    logic [spp_pkg::NPINS-1:0] level;    // Conditioned level, no analog gate
    logic [spp_pkg::NPINS-1:0] read_val; // Digital read value

    modport ctl  (output thr_sel, output ana_sel,
                  input  level,   input  read_val);
    modport cond (input  thr_sel, input  ana_sel,
                  output level,   output read_val);
endinterface

//--- design/spp_pin_cond.sv
// Pin input conditioner: synchronises both threshold comparator outputs
// of every pin and picks one by the threshold select.
// Assumes pad inputs are asynchronous to aclk.
`timescale 1ns/1ps
module spp_pin_cond (
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // Comparator outputs from the pads
    input  wire logic [spp_pkg::NPINS-1:0] pad_st_in,
    input  wire logic [spp_pkg::NPINS-1:0] pad_ttl_in,
    // Control side
    spp_cond_if.cond                       cif
);
    localparam int N = spp_pkg::NPINS;

    logic [N-1:0] st_s1_ff;   // First sync stage, Schmitt
    logic [N-1:0] st_s2_ff;   // Second sync stage, Schmitt
    logic [N-1:0] ttl_s1_ff;  // First sync stage, TTL
    logic [N-1:0] ttl_s2_ff;  // Second sync stage, TTL
    logic [N-1:0] level_ff;   // Selected level
    logic [N-1:0] read_ff;    // Level with analog gate
    logic [N-1:0] nxt_level;  // Next selected level
    logic [N-1:0] nxt_read;   // Next read value

    // Per pin threshold choice and analog gate
    for (genvar i = 0; i < N; i++) begin : g_pin
        assign nxt_level[i] = (cif.thr_sel[i] == spp_pkg::THR_SCHMITT) ?
                              st_s2_ff[i] : ttl_s2_ff[i];
        assign nxt_read[i]  = nxt_level[i] & ~cif.ana_sel[i];
    end

    // Register synchronisers and conditioned values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_s1_ff  <= '0;
            st_s2_ff  <= '0;
            ttl_s1_ff <= '0;
            ttl_s2_ff <= '0;
            level_ff  <= '0;
            read_ff   <= '0;
        end else begin
            st_s1_ff  <= pad_st_in;
            st_s2_ff  <= st_s1_ff;
            ttl_s1_ff <= pad_ttl_in;
            ttl_s2_ff <= ttl_s1_ff;
            level_ff  <= nxt_level;
            read_ff   <= nxt_read;
        end
    end

    assign cif.level    = level_ff;
    assign cif.read_val = read_ff;

endmodule

//--- design/spp_port_top.sv
// Six-pin general purpose port with pin steering, AXI4-Lite slave.
// Assumes pad comparator outputs are asynchronous and peripheral
// requests arrive on aclk.
// How it works
// - six pins, each direction and read, latch on all but pin three
// - direction one turns pin driver off
// - direction zero drives latch onto pin
// - pin three input only, direction reads one
// - value reads pins, value writes latch
// - value write merges pin levels into latch
// - direction controls driver even in analog
// - analog pin digital read returns zero
// - analog select never blocks digital output
// - reset sets every analog select bit
// - per pin Schmitt or TTL threshold
// - threshold feeds reads and change level
// - steer bit one moves pwm2 second output
// - steering leaves direction bits untouched
// - highest priority peripheral owns shared pin
`timescale 1ns/1ps
module spp_port_top #(
    parameter int NPINS = spp_pkg::NPINS  // Pin count, fixed map
) (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write address
    input  wire logic [spp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [spp_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Pads
    input  wire logic [5:0]                 pad_st_in,
    input  wire logic [5:0]                 pad_ttl_in,
    output logic [5:0]                      pad_out,
    output logic [5:0]                      pad_oe,
    // Conditioned levels for change detection elsewhere
    output logic [5:0]                      in_level,
    // Fixed higher priority peripherals per pin
    input  wire logic [5:0]                 hp_out,
    input  wire logic [5:0]                 hp_oe,
    // Steerable peripheral functions, index is steer bit
    input  wire logic [5:0]                 func_out,
    input  wire logic [5:0]                 func_oe,
    // Serial 2 select input as taken from port C
    input  wire logic                       pc_serial2_select,
    output logic                            serial2_select_in,
    // Steered outputs towards port C
    output logic [5:0]                      dflt_out,
    output logic [5:0]                      dflt_oe,
    output logic [5:0]                      alt_out,
    output logic [5:0]                      alt_oe
);
    // Fixed pin map cannot serve another pin count
    if (NPINS != 6) begin : g_bad_npins
        $error("spp_port_top: NPINS must be 6");
    end

    // Register state
    logic [5:0]  dir_ff;        // Direction bits
    logic [5:0]  latch_ff;      // Output latch
    logic [5:0]  ana_ff;        // Analog select bits
    logic [5:0]  thr_ff;        // Threshold select bits
    logic [5:0]  steer_ff;      // Pin steering control 0
    logic [5:0]  nxt_dir;
    logic [5:0]  nxt_latch;
    logic [5:0]  nxt_ana;
    logic [5:0]  nxt_thr;
    logic [5:0]  nxt_steer;

    // Write channel state
    logic        aw_full_ff;    // Write address held
    logic        w_full_ff;     // Write data held
    logic [7:0]  awaddr_ff;     // Held write address
    logic [5:0]  wdata_ff;      // Held write data, low bits
    logic        wstrb0_ff;     // Held strobe of byte 0
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        nxt_aw_full;
    logic        nxt_w_full;
    logic [7:0]  nxt_awaddr;
    logic [5:0]  nxt_wdata;
    logic        nxt_wstrb0;
    logic        nxt_awready;
    logic        nxt_wready;
    logic        nxt_bvalid;
    logic [1:0]  nxt_bresp;

    // Read channel state
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        nxt_arready;
    logic        nxt_rvalid;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;

    // Pin and routing state
    logic [5:0]  pad_out_ff;
    logic [5:0]  pad_oe_ff;
    logic        ss_in_ff;
    logic [5:0]  dflt_out_ff;
    logic [5:0]  dflt_oe_ff;
    logic [5:0]  alt_out_ff;
    logic [5:0]  alt_oe_ff;
    logic [5:0]  nxt_pad_out;
    logic [5:0]  nxt_pad_oe;
    logic        nxt_ss_in;
    logic [5:0]  nxt_dflt_out;
    logic [5:0]  nxt_dflt_oe;
    logic [5:0]  nxt_alt_out;
    logic [5:0]  nxt_alt_oe;

    // Steered requests landing on this port, per line
    logic [5:0]  st_en;
    logic [5:0]  st_dat;
    logic [5:0]  drive_val;

    // Input conditioner link
    spp_cond_if cif ();

    // Input conditioner, synchronises pads and applies threshold
    spp_pin_cond u_cond (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pad_st_in  (pad_st_in),
        .pad_ttl_in (pad_ttl_in),
        .cif        (cif.cond)
    );

    assign cif.thr_sel = thr_ff;
    assign cif.ana_sel = ana_ff;

    // Register bus: channel handshakes and register updates
    always_comb begin
        logic aw_take;
        logic w_take;
        logic ar_take;
        logic wr_go;
        aw_take     = s_axi_awvalid & awready_ff;
        w_take      = s_axi_wvalid & wready_ff;
        ar_take     = s_axi_arvalid & arready_ff;
        wr_go       = aw_full_ff & w_full_ff & ~bvalid_ff;
        nxt_dir     = dir_ff;
        nxt_latch   = latch_ff;
        nxt_ana     = ana_ff;
        nxt_thr     = thr_ff;
        nxt_steer   = steer_ff;
        nxt_awaddr  = aw_take ? s_axi_awaddr : awaddr_ff;
        nxt_wdata   = w_take ? s_axi_wdata[5:0] : wdata_ff;
        nxt_wstrb0  = w_take ? s_axi_wstrb[0] : wstrb0_ff;
        nxt_aw_full = aw_full_ff | aw_take;
        nxt_w_full  = w_full_ff | w_take;
        nxt_bvalid  = bvalid_ff & ~s_axi_bready;
        nxt_bresp   = bresp_ff;
        // Perform a write once address and data are both held
        if (wr_go) begin
            nxt_aw_full = 1'b0;
            nxt_w_full  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = spp_pkg::RESP_OKAY;
            case (awaddr_ff)
                spp_pkg::OFS_PIN_VALUE: begin
                    // Merge written byte over the pin levels read now
                    nxt_latch = (wstrb0_ff ? wdata_ff : cif.read_val)
                                & spp_pkg::LATCH_MASK;
                end
                spp_pkg::OFS_DIRECTION: begin
                    if (wstrb0_ff) begin
                        nxt_dir = wdata_ff | spp_pkg::DIR_FORCE1;
                    end
                end
                spp_pkg::OFS_LATCH: begin
                    if (wstrb0_ff) begin
                        nxt_latch = wdata_ff & spp_pkg::LATCH_MASK;
                    end
                end
                spp_pkg::OFS_ANALOG: begin
                    if (wstrb0_ff) begin
                        nxt_ana = wdata_ff;
                    end
                end
                spp_pkg::OFS_THRESH: begin
                    if (wstrb0_ff) begin
                        nxt_thr = wdata_ff;
                    end
                end
                spp_pkg::OFS_STEER0: begin
                    // Only six bits exist, upper bits are dropped
                    if (wstrb0_ff) begin
                        nxt_steer = wdata_ff;
                    end
                end
                default: begin
                    // Unmapped address
                    nxt_bresp = spp_pkg::RESP_SLVERR;
                end
            endcase
        end
        nxt_awready = ~nxt_aw_full & ~nxt_bvalid;
        nxt_wready  = ~nxt_w_full & ~nxt_bvalid;
        // Read: answer one cycle after the address is taken
        nxt_rvalid  = rvalid_ff & ~s_axi_rready;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (ar_take) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = spp_pkg::RESP_OKAY;
            case (s_axi_araddr)
                spp_pkg::OFS_PIN_VALUE: begin
                    nxt_rdata = 32'(cif.read_val);
                end
                spp_pkg::OFS_DIRECTION: begin
                    nxt_rdata = 32'(dir_ff);
                end
                spp_pkg::OFS_LATCH: begin
                    nxt_rdata = 32'(latch_ff);
                end
                spp_pkg::OFS_ANALOG: begin
                    nxt_rdata = 32'(ana_ff);
                end
                spp_pkg::OFS_THRESH: begin
                    nxt_rdata = 32'(thr_ff);
                end
                spp_pkg::OFS_STEER0: begin
                    nxt_rdata = 32'(steer_ff);
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = spp_pkg::RESP_SLVERR;
                end
            endcase
        end
        nxt_arready = ~nxt_rvalid;
    end

    // Register bus and register file flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_ff     <= spp_pkg::RST_DIRECTION;
            latch_ff   <= spp_pkg::RST_LATCH;
            ana_ff     <= spp_pkg::RST_ANALOG;
            thr_ff     <= spp_pkg::RST_THRESH;
            steer_ff   <= spp_pkg::RST_STEER0;
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 6'h00;
            wstrb0_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= spp_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= spp_pkg::RESP_OKAY;
        end else begin
            dir_ff     <= nxt_dir;
            latch_ff   <= nxt_latch;
            ana_ff     <= nxt_ana;
            thr_ff     <= nxt_thr;
            steer_ff   <= nxt_steer;
            aw_full_ff <= nxt_aw_full;
            w_full_ff  <= nxt_w_full;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb0_ff  <= nxt_wstrb0;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    // Steered outputs whose alternate pin lies on this port
    always_comb begin
        logic dout_on4;
        logic pwm_on4;
        dout_on4 = steer_ff[spp_pkg::STB_SERIAL2_DOUT]
                   & func_oe[spp_pkg::STB_SERIAL2_DOUT];
        pwm_on4  = steer_ff[spp_pkg::STB_PWM2_OUT2]
                   & func_oe[spp_pkg::STB_PWM2_OUT2];
        st_en    = 6'h00;
        st_dat   = 6'h00;
        // Serial data out outranks the pwm output on line 4
        st_en[spp_pkg::PA_LINE4]  = dout_on4 | pwm_on4;
        st_dat[spp_pkg::PA_LINE4] = dout_on4 ?
            func_out[spp_pkg::STB_SERIAL2_DOUT] :
            func_out[spp_pkg::STB_PWM2_OUT2];
        st_en[spp_pkg::PA_LINE5]  = steer_ff[spp_pkg::STB_CAPTURE2]
                                    & func_oe[spp_pkg::STB_CAPTURE2];
        st_dat[spp_pkg::PA_LINE5] = func_out[spp_pkg::STB_CAPTURE2];
    end

    // Per pin output source: fixed peripheral, steered, then latch
    for (genvar i = 0; i < 6; i++) begin : g_drive
        assign drive_val[i] = hp_oe[i] ? hp_out[i] :
                              st_en[i] ? st_dat[i] : latch_ff[i];
    end

    // Pad drive and routing towards port C
    always_comb begin
        // Driver follows direction only, never analog select
        nxt_pad_oe  = ~dir_ff & ~spp_pkg::DIR_FORCE1;
        nxt_pad_out = drive_val;
        // Functions on their default pin go out to port C
        nxt_dflt_oe  = func_oe & ~steer_ff & spp_pkg::OUT_FUNCS;
        nxt_dflt_out = func_out & nxt_dflt_oe;
        // Alternates not on this port also go to port C
        nxt_alt_oe   = func_oe & steer_ff & spp_pkg::OUT_FUNCS
                       & ~spp_pkg::ALT_ON_PA;
        nxt_alt_out  = func_out & nxt_alt_oe;
        // Select input comes from line 3 when steered here
        nxt_ss_in = steer_ff[spp_pkg::STB_SERIAL2_SEL] ?
                    cif.level[spp_pkg::PIN_INPUT_ONLY] :
                    pc_serial2_select;
    end

    // Pad and routing flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_out_ff  <= 6'h00;
            pad_oe_ff   <= 6'h00;
            ss_in_ff    <= 1'b0;
            dflt_out_ff <= 6'h00;
            dflt_oe_ff  <= 6'h00;
            alt_out_ff  <= 6'h00;
            alt_oe_ff   <= 6'h00;
        end else begin
            pad_out_ff  <= nxt_pad_out;
            pad_oe_ff   <= nxt_pad_oe;
            ss_in_ff    <= nxt_ss_in;
            dflt_out_ff <= nxt_dflt_out;
            dflt_oe_ff  <= nxt_dflt_oe;
            alt_out_ff  <= nxt_alt_out;
            alt_oe_ff   <= nxt_alt_oe;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready     = awready_ff;
    assign s_axi_wready      = wready_ff;
    assign s_axi_bvalid      = bvalid_ff;
    assign s_axi_bresp       = bresp_ff;
    assign s_axi_arready     = arready_ff;
    assign s_axi_rvalid      = rvalid_ff;
    assign s_axi_rdata       = rdata_ff;
    assign s_axi_rresp       = rresp_ff;
    assign pad_out           = pad_out_ff;
    assign pad_oe            = pad_oe_ff;
    assign in_level          = cif.level;
    assign serial2_select_in = ss_in_ff;
    assign dflt_out          = dflt_out_ff;
    assign dflt_oe           = dflt_oe_ff;
    assign alt_out           = alt_out_ff;
    assign alt_oe            = alt_oe_ff;

endmodule

//--- verif/spp_pad_model.sv
// Pad model: the far side of the six pins.
// Assumes the bench sets the undriven pin levels per threshold.
`timescale 1ns/1ps
module spp_pad_model (
    // Drive from the port and levels from outside
    input  wire logic [5:0] pad_out,
    input  wire logic [5:0] pad_oe,
    input  wire logic [5:0] ext_st,
    input  wire logic [5:0] ext_ttl,
    // Comparator outputs back to the port
    output logic      [5:0] pad_st_in,
    output logic      [5:0] pad_ttl_in
);
    // A driven pin shows its drive at both thresholds
    assign pad_st_in  = (pad_oe & pad_out) | (~pad_oe & ext_st);
    assign pad_ttl_in = (pad_oe & pad_out) | (~pad_oe & ext_ttl);
endmodule

//--- verif/spp_port_monitor.sv
// Assertion checker for the six-pin port top.
// Assumes it is bound onto spp_port_top, one clock domain.
`timescale 1ns/1ps
module spp_port_chk (
    // Clock, reset, bus handshakes
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // Pins and steered enables
    input wire logic [5:0]  pad_out, pad_oe, hp_out, hp_oe, dflt_oe, alt_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Write and read requests taken
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_rst;
        disable iff (1'b0) !aresetn |=> (pad_oe | alt_oe | dflt_oe) == 6'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs live in reset");
    property p_pin3;
        !pad_oe[3];
    endproperty
    a_pin3: assert property (p_pin3) else $error("pin 3 driven");
    property p_wr;
        s_wr |-> ##2 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_rd;
        s_rd |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_hi;
        s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_oe;
        $changed(pad_oe) |-> s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_oe: assert property (p_oe) else $error("enable moved alone");
    property p_alt;
        (alt_oe & 6'h33) == 6'h0 && !dflt_oe[4];
    endproperty
    a_alt: assert property (p_alt) else $error("bad steered enable");
    property p_hp;
        1 |=> ((pad_out ^ $past(hp_out)) & $past(hp_oe & pad_oe) & pad_oe)
              == 6'h0;
    endproperty
    a_hp: assert property (p_hp) else $error("priority lost");
endmodule
bind spp_port_top spp_port_chk i_spp_port_chk (.*);

//--- verif/tb_top.sv
// Self-checking bench for the six-pin port over AXI4-Lite.
// Assumes the pad model and the bound checker are compiled.
`timescale 1ns/1ps
module tb_top;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic pc_serial2_select = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, serial2_select_in;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0] s_axi_wstrb = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [5:0] hp_out = 0, hp_oe = 0, func_out = 0, func_oe = 0;
    logic [5:0] ext_st = 0, ext_ttl = 0, pad_st_in, pad_ttl_in, pad_out;
    logic [5:0] pad_oe, in_level, dflt_out, dflt_oe, alt_out, alt_oe;
    logic [5:0] v, t, s, lv;
    logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [5:0] rst [7] = '{6'h00, 6'h3f, 6'h00, 6'h3f, 6'h00, 6'h00, 6'h00};
    int n_fail = 0, checks_done = 0;
    spp_port_top i_spp_port_top (.*);
    spp_pad_model i_spp_pad_model (.*);
    initial forever #2.5 aclk = ~aclk;
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus write, address and data offered together
    task automatic wr(logic [7:0] a, logic [7:0] d, logic [3:0] st);
        bit aw = 1, w = 1;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d}; s_axi_wstrb <= st;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        // Release each channel at the edge that takes it
        while (aw || w) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        rs = s_axi_bresp; s_axi_bready <= 0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_d = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0;
    endtask
    // Expected pin drive with every pin but pin 3 an output
    function automatic logic [5:0] drv(logic [5:0] l, logic [5:0] sb);
        drv = l & 6'h37;
        if (sb[0] && func_oe[0]) drv[5] = func_out[0];
        if (sb[1] && func_oe[1]) drv[4] = func_out[1];
        if (sb[5] && func_oe[5]) drv[4] = func_out[5];
        drv = ((hp_oe & hp_out) | (~hp_oe & drv)) & 6'h37;
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100us;
        n_fail++;
        end_of_test();
    end
    initial begin
        void'($urandom(72844));
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        // Reset values, then an unmapped place
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk(rd_d, rst[i]);
            chk(rs, i == 6 ? 2'h2 : 2'h0);
        end
        wr(8'h18, 8'h3f, 4'hf);
        chk(rs, 2'h2);
        wr(8'h04, 8'h00, 4'hf);
        rd(8'h04);
        chk(rd_d, 8'h08);
        v = 6'($urandom);
        wr(8'h08, {2'h3, v}, 4'hf);
        rd(8'h08);
        chk(rd_d, v & 6'h37);
        chk(pad_oe, 6'h37);
        chk(pad_out, v & 6'h37);
        // Inputs while still analog, then digital
        wr(8'h04, 8'h3f, 4'hf);
        ext_st <= 6'($urandom);
        ext_ttl <= 6'($urandom);
        rd(8'h00);
        chk(rd_d, 0);
        chk(pad_oe, 6'h00);
        t = 6'($urandom);
        wr(8'h10, {2'h0, t}, 4'hf);
        wr(8'h0c, 8'h00, 4'hf);
        repeat (4) @(posedge aclk);
        lv = (t & ext_st) | (~t & ext_ttl);
        rd(8'h00);
        chk(rd_d, lv);
        chk(in_level, lv);
        wr(8'h00, 8'hff, 4'h0);
        rd(8'h08);
        chk(rd_d, lv & 6'h37);
        wr(8'h00, {2'h0, ~v}, 4'h1);
        rd(8'h08);
        chk(rd_d, ~v & 6'h37);
        wr(8'h04, 8'h00, 4'hf);
        // Steering with random peripheral requests
        repeat (12) begin
            s = 6'($urandom);
            hp_oe <= 6'($urandom) & 6'h37;
            hp_out <= 6'($urandom);
            func_oe <= 6'($urandom);
            func_out <= 6'($urandom);
            pc_serial2_select <= 1'($urandom);
            wr(8'h14, {2'h3, s}, 4'hf);
            chk(rs, 2'h0);
            rd(8'h14);
            chk(rd_d, s);
            rd(8'h04);
            chk(rd_d, 8'h08);
            chk(pad_out & 6'h37, drv(~v, s));
            chk(dflt_oe, ~s & func_oe & 6'h2f);
            chk(alt_oe, s & func_oe & 6'h0c);
            chk(dflt_out, ~s & func_oe & func_out & 6'h2f);
            chk(alt_out, s & func_oe & func_out & 6'h0c);
            chk(alt_oe[3] | dflt_oe[1], (s[3] | ~s[1]) & 1'b0 |
                (s[3] & func_oe[3]) | (~s[1] & func_oe[1]));
            chk(serial2_select_in, s[4] ? lv[3] : pc_serial2_select);
        end
        // Mid-run reset brings back the reset values
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(8'h0c);
        chk(rd_d, 6'h3f);
        rd(8'h14);
        chk(rd_d, 6'h00);
        end_of_test();
    end
endmodule
